// file: src/tmu_glue.sv
/*
 * Shared glue of a five-timer general purpose timer unit: window and
 * register decode, input source selector, identity register, control
 * register storage, forwarding of count and capture/reload accesses to
 * the timer cores, interrupt request lines and the timer six wrap pulse.
 * Assumes the timer cores run on i_clk and hold the count and
 * capture/reload values themselves; all inputs are synchronous to i_clk.
 */
// The address-and-strobe port was left to the implementer.
// What this block does and what it relies on
// R1: Selector bit 0 picks timer two count source
// R2: Selector bit 1 picks timer two direction source
// R3: Selector [3:2] picks timer three count source
// R4: Selector [5:4] picks timer three direction source
// R5: Selector [7:6] picks timer four count source
// R6: Selector [9:8] picks timer four direction source
// R7: Bits 10, 11 pick timer five sources
// R8: Bits 12, 13 pick timer six sources
// R9: Selector [15:14] picks capture trigger source
// R10: Selector resets to zero, legacy routing
// R11: Identity bits [7:0] give revision, first 01
// R12: Identity bits [15:8] give unit type code
// R13: Thirteen registers decoded at offsets 00 to 30
// R14: Window 40010000 to 40013FFF, base plus offset
// R15: Timer prescaling derives from system clock directly
// R16: Six interrupt request outputs drive the controller
// R17: Export pulse on each timer six wrap
// R18: Disabled: reads work, only selector, timer-five control write
// R19: Software sets pin directions and selects pins
// R20: Software picks rising edge for read triggers
// R21: Identity writes ignored, unused offsets read zero
`timescale 1ns/1ns
`default_nettype none

module tmu_glue
   import tmu_pkg::*;
#(
   parameter int          DATA_W    = 32,
   parameter logic [7:0]  REVISION  = 8'h01,
   parameter logic [7:0]  UNIT_TYPE = 8'hA7   // Arbitrary value
)
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // Register port
   input  wire logic [31:0]       i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   // Unit disable from the power management
   input  wire logic              i_unit_disable,
   // Timer input candidates and routed inputs
   input  wire tmu_src_t          i_src,
   output var  tmu_routed_t       o_routed,
   // Control registers towards the cores, timer two first
   output logic      [4:0][15:0]  o_ctrl,
   // Capture/reload and counts held by the cores, capture/reload first
   input  wire logic [5:0][15:0]  i_core_value,
   output logic      [5:0]        o_core_wr,
   output logic      [15:0]       o_core_wdata,
   // Interrupt events from the cores, timers two to six then capture
   input  wire logic [5:0]        i_irq_event,
   output logic      [5:0]        o_irq,
   // Wrap event of timer six from its core
   input  wire logic              i_tmr_f_wrap,
   output logic                   o_timer_six_wrap_pulse
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   // Registers are 16 bits wide and must fit the data path
   if (DATA_W < 16 || DATA_W > 64)
   begin : g_bad_width
      $error("tmu_glue: DATA_W must lie between 16 and 64");
   end

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   // Maps a byte address to a register index, IDX_NONE when unmapped
   function automatic logic [3:0] reg_index(input logic [31:0] addr);
      logic [13:0] ofs;
      logic [3:0]  idx;
      ofs = addr[13:0];
      idx = IDX_NONE;
      // Window base plus offset gives the absolute address
      if (addr >= TMU_WIN_BASE && addr <= TMU_WIN_LAST)   // [R14]
      begin
         // Word aligned offsets 00 to 30 only
         if (ofs[1:0] == 2'b00 && ofs[13:6] == 8'h00)     // [R13]
         begin
            if (ofs[5:2] <= IDX_LAST)
               idx = ofs[5:2];
         end
      end
      reg_index = idx;
   endfunction

   // True for an index that software may write while disabled
   function automatic logic writable_when_off(input logic [3:0] idx);
      writable_when_off = (idx == IDX_SEL) || (idx == IDX_CTL_E);  // [R18]
   endfunction

   logic [3:0]  acc_idx;
   logic        wr_ok;
   logic [15:0] wdata16;

   assign acc_idx = reg_index(i_addr);
   assign wdata16 = i_wdata[15:0];

   // Write gate: mapped, and while disabled only the two listed registers
   assign wr_ok = i_wr && (acc_idx != IDX_NONE) && (acc_idx != IDX_IDENT)  // [R21]
                  && (!i_unit_disable || writable_when_off(acc_idx));        // [R18]

   ////////////////////////////////////////////////////////////////////////
   // Input source selector

   tmu_sel_t src_sel;

   // Selector starts on the first-listed source of every input
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         src_sel <= tmu_sel_t'(RST_SELECT);                // [R10]
      else if (wr_ok && acc_idx == IDX_SEL)
         src_sel <= tmu_sel_t'(wdata16);
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers of timers two to six

   // Contents are interpreted by the cores; stored here to share decode
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < 5; i++)
            o_ctrl[i] <= RST_CONTROL;
      end
      else if (wr_ok && acc_idx >= IDX_CTL_B && acc_idx <= IDX_CTL_F)
      begin
         o_ctrl[3'(acc_idx - IDX_CTL_B)] <= wdata16;        // [R18]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Forwarding of capture/reload and count writes

   // Core registers take the value one cycle after the strobe
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_core_wr    <= '0;
         o_core_wdata <= 16'h0000;
      end
      else
      begin
         o_core_wr <= '0;
         if (wr_ok && acc_idx >= IDX_CAPRL && acc_idx <= IDX_LAST)
         begin
            o_core_wr[3'(acc_idx - IDX_CAPRL)] <= 1'b1;     // [R13]
            o_core_wdata                       <= wdata16;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path

   logic [15:0] identity_word;
   logic [15:0] next_rdata16;

   // Read-only identity: type code above, revision below
   assign identity_word = {UNIT_TYPE, REVISION};            // [R11] [R12]

   // Read mux; reads stay served while the unit is disabled
   always_comb
   begin
      next_rdata16 = 16'h0000;                             // [R21]
      if (i_rd)                                            // [R18]
      begin
         case (acc_idx)
            IDX_IDENT: next_rdata16 = identity_word;       // [R11] [R12]
            IDX_SEL:   next_rdata16 = 16'(src_sel);
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
               next_rdata16 = o_ctrl[3'(acc_idx - IDX_CTL_B)];
            4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC:
               next_rdata16 = i_core_value[3'(acc_idx - IDX_CAPRL)];
            default:   next_rdata16 = 16'h0000;            // [R21]
         endcase
      end
   end

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_rdata <= '0;
      else
         o_rdata <= DATA_W'(next_rdata16);
   end

   ////////////////////////////////////////////////////////////////////////
   // Internal read triggers for the capture path

   logic rd_c_count;
   logic rd_bcd_count;

   // Reads of the timer three count, and of timers two to four.
   // A one-cycle pulse: the capture edge detector must look for a rise.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         rd_c_count   <= 1'b0;
         rd_bcd_count <= 1'b0;
      end
      else
      begin
         rd_c_count   <= i_rd && (acc_idx == IDX_CNT_C);               // [R9]
         rd_bcd_count <= i_rd && (acc_idx >= 4'h8) && (acc_idx <= 4'hA); // [R9] [R20]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input routing

   // Pins arrive already set to input by software
   tmu_input_router u_router                               // [R19]
   (
      .i_clk          (i_clk),
      .i_rst_n        (i_rst_n),
      .i_sel          (src_sel),
      .i_src          (i_src),
      .i_rd_c_count   (rd_c_count),
      .i_rd_bcd_count (rd_bcd_count),
      .o_routed       (o_routed)
   );

   ////////////////////////////////////////////////////////////////////////
   // Interrupt request lines

   // One line each for timers two to six and one for capture/reload;
   // registered so the controller sees clean pulses
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_irq <= '0;
      else
         o_irq <= i_irq_event;                             // [R16]
   end

   ////////////////////////////////////////////////////////////////////////
   // Timer six wrap export

   // Core runs on i_clk with no divider, so a wrap is one clock long
   always_ff @(posedge i_clk)                              // [R15]
   begin
      if (!i_rst_n)
         o_timer_six_wrap_pulse <= 1'b0;
      else
         o_timer_six_wrap_pulse <= i_tmr_f_wrap;           // [R17]
   end

endmodule

`default_nettype wire

// file: common/tmu_pkg.sv
/*
 * Package of the timer unit glue: register map, field layout of the
 * input source selector, reset values and the carriers between files.
 * Assumes a 32-bit byte address and one aligned word per register.
 */
`default_nettype none

package tmu_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Address window of the unit
   localparam logic [31:0] TMU_WIN_BASE = 32'h4001_0000;
   localparam logic [31:0] TMU_WIN_LAST = 32'h4001_3FFF;

   // Byte offsets inside the window
   localparam logic [13:0] OFS_MODULE_IDENTITY     = 14'h0000;
   localparam logic [13:0] OFS_INPUT_SOURCE_SELECT = 14'h0004;
   localparam logic [13:0] OFS_TIMER_TWO_CONTROL   = 14'h0008;
   localparam logic [13:0] OFS_TIMER_THREE_CONTROL = 14'h000C;
   localparam logic [13:0] OFS_TIMER_FOUR_CONTROL  = 14'h0010;
   localparam logic [13:0] OFS_TIMER_FIVE_CONTROL  = 14'h0014;
   localparam logic [13:0] OFS_TIMER_SIX_CONTROL   = 14'h0018;
   localparam logic [13:0] OFS_CAPTURE_RELOAD      = 14'h001C;
   localparam logic [13:0] OFS_TIMER_TWO_COUNT     = 14'h0020;
   localparam logic [13:0] OFS_TIMER_THREE_COUNT   = 14'h0024;
   localparam logic [13:0] OFS_TIMER_FOUR_COUNT    = 14'h0028;
   localparam logic [13:0] OFS_TIMER_FIVE_COUNT    = 14'h002C;
   localparam logic [13:0] OFS_TIMER_SIX_COUNT     = 14'h0030;

   // Register index: word offset, 4'hF marks an unmapped address
   localparam logic [3:0] IDX_IDENT = 4'h0;
   localparam logic [3:0] IDX_SEL   = 4'h1;
   localparam logic [3:0] IDX_CTL_B = 4'h2;
   localparam logic [3:0] IDX_CTL_E = 4'h5;
   localparam logic [3:0] IDX_CTL_F = 4'h6;
   localparam logic [3:0] IDX_CAPRL = 4'h7;
   localparam logic [3:0] IDX_CNT_C = 4'h9;
   localparam logic [3:0] IDX_LAST  = 4'hC;
   localparam logic [3:0] IDX_NONE  = 4'hF;

   // Reset values
   localparam logic [15:0] RST_SELECT  = 16'h0000;
   localparam logic [15:0] RST_CONTROL = 16'h0000;

   // Identity fields
   localparam int IDENT_REV_LSB  = 0;
   localparam int IDENT_TYPE_LSB = 8;

   ////////////////////////////////////////////////////////////////////////
   // Selector layout, most significant field first
   typedef struct packed {
      logic [1:0] capture_trigger_src_sel;  // [15:14]
      logic       tmr_f_dir_src_sel;        // 13
      logic       tmr_f_count_src_sel;      // 12
      logic       tmr_e_dir_src_sel;        // 11
      logic       tmr_e_count_src_sel;      // 10
      logic [1:0] tmr_d_dir_src_sel;        // [9:8]
      logic [1:0] tmr_d_count_src_sel;      // [7:6]
      logic [1:0] tmr_c_dir_src_sel;        // [5:4]
      logic [1:0] tmr_c_count_src_sel;      // [3:2]
      logic       tmr_b_dir_src_sel;        // 1
      logic       tmr_b_count_src_sel;      // 0
   } tmu_sel_t;

   // Candidate sources, first-listed source in bit 0
   typedef struct packed {
      logic [1:0] b_count;
      logic [1:0] b_dir;
      logic [3:0] c_count;
      logic [3:0] c_dir;
      logic [3:0] d_count;
      logic [3:0] d_dir;
      logic [1:0] e_count;
      logic [1:0] e_dir;
      logic [1:0] f_count;
      logic [1:0] f_dir;
      logic [1:0] capture_pin;
   } tmu_src_t;

   // Routed inputs as the timer cores see them
   typedef struct packed {
      logic b_count;
      logic b_dir;
      logic c_count;
      logic c_dir;
      logic d_count;
      logic d_dir;
      logic e_count;
      logic e_dir;
      logic f_count;
      logic f_dir;
      logic capture_trigger_input;
   } tmu_routed_t;

endpackage

`default_nettype wire

// file: src/tmu_input_router.sv
/*
 * Input router: steers the candidate sources of each timer input and of
 * the capture trigger by the selector fields. Outputs are registered.
 * Assumes all sources are synchronous to i_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module tmu_input_router
   import tmu_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire tmu_sel_t    i_sel,
   input  wire tmu_src_t    i_src,
   input  wire logic        i_rd_c_count,
   input  wire logic        i_rd_bcd_count,
   output var  tmu_routed_t o_routed
);

   ////////////////////////////////////////////////////////////////////////
   // Picks one of up to four candidates
   function automatic logic pick4(input logic [3:0] cand, input logic [1:0] sel);
      pick4 = cand[sel];
   endfunction

   tmu_routed_t next_routed;
   logic [3:0]  capture_cand;

   // Last two capture candidates are the internal read strobes
   assign capture_cand = {i_rd_bcd_count, i_rd_c_count, i_src.capture_pin};

   // Source selection per timer input
   always_comb
   begin
      next_routed.b_count = i_src.b_count[i_sel.tmr_b_count_src_sel];  // [R1]
      next_routed.b_dir   = i_src.b_dir[i_sel.tmr_b_dir_src_sel];      // [R2]
      next_routed.c_count = pick4(i_src.c_count, i_sel.tmr_c_count_src_sel); // [R3]
      next_routed.c_dir   = pick4(i_src.c_dir, i_sel.tmr_c_dir_src_sel);     // [R4]
      next_routed.d_count = pick4(i_src.d_count, i_sel.tmr_d_count_src_sel); // [R5]
      next_routed.d_dir   = pick4(i_src.d_dir, i_sel.tmr_d_dir_src_sel);     // [R6]
      next_routed.e_count = i_src.e_count[i_sel.tmr_e_count_src_sel];  // [R7]
      next_routed.e_dir   = i_src.e_dir[i_sel.tmr_e_dir_src_sel];      // [R7]
      next_routed.f_count = i_src.f_count[i_sel.tmr_f_count_src_sel];  // [R8]
      next_routed.f_dir   = i_src.f_dir[i_sel.tmr_f_dir_src_sel];      // [R8]
      next_routed.capture_trigger_input =
         pick4(capture_cand, i_sel.capture_trigger_src_sel);           // [R9]
   end

   // One register stage keeps the cores' edge detectors glitch free
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_routed <= '0;
      else
         o_routed <= next_routed;
   end

endmodule

`default_nettype wire

// file: sim/tmu_glue_sva.sv
/*
 * Checker of the timer unit glue: register port answers and event outputs.
 * Assumes the glue top ports only; bound to every tmu_glue instance.
 */
`timescale 1ns/1ns
`default_nettype none

module tmu_glue_sva
   import tmu_pkg::*;
#(
   parameter int         DATA_W    = 32,
   parameter logic [7:0] REVISION  = 8'h01,
   parameter logic [7:0] UNIT_TYPE = 8'hA7  // Arbitrary value
)
(
   input wire logic              i_clk,
   input wire logic              i_rst_n,
   input wire logic [31:0]       i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic              i_unit_disable,
   input wire tmu_src_t          i_src,
   input wire tmu_routed_t       o_routed,
   input wire logic [4:0][15:0]  o_ctrl,
   input wire logic [5:0][15:0]  i_core_value,
   input wire logic [5:0]        o_core_wr,
   input wire logic [15:0]       o_core_wdata,
   input wire logic [5:0]        i_irq_event,
   input wire logic [5:0]        o_irq,
   input wire logic              i_tmr_f_wrap,
   input wire logic              o_timer_six_wrap_pulse
);
   localparam logic [31:0] A_SEL = TMU_WIN_BASE + 32'h0000_0004;
   localparam logic [31:0] A_CB  = TMU_WIN_BASE + 32'h0000_0008;
   localparam logic [31:0] A_CE  = TMU_WIN_BASE + 32'h0000_0014;
   localparam logic [31:0] A_NC  = TMU_WIN_BASE + 32'h0000_0024;
   localparam logic [31:0] A_ND  = TMU_WIN_BASE + 32'h0000_0028;

   // Plain nets so the sampled-value functions see signals only
   wire logic [15:0] wlo;
   wire logic [15:0] cnt_d;
   wire logic [15:0] ctl_b;
   wire logic [15:0] ctl_e;
   wire logic        in_win;
   assign wlo    = i_wdata[15:0];
   assign cnt_d  = i_core_value[3];
   assign ctl_b  = o_ctrl[0];
   assign ctl_e  = o_ctrl[3];
   assign in_win = (i_addr >= TMU_WIN_BASE) && (i_addr <= TMU_WIN_LAST);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   ////////////////////////////////////////////////////////////////////////
   // Selector write followed by its readback
   sequence s_wr_sel;
      i_wr && i_addr == A_SEL;
   endsequence
   sequence s_rd_sel;
      i_rd && i_addr == A_SEL;
   endsequence
   property p_sel_back;
      s_wr_sel ##1 s_rd_sel |=> o_rdata == DATA_W'($past(wlo, 2));
   endproperty
   a_sel_back: assert property (p_sel_back)
      else $error("selector readback differs");
   property p_ident;
      i_rd && i_addr == TMU_WIN_BASE |=> o_rdata == DATA_W'({UNIT_TYPE, REVISION});
   endproperty
   a_ident: assert property (p_ident)
      else $error("identity value wrong");
   property p_idle;
      !i_rd |=> o_rdata == '0;
   endproperty
   a_idle: assert property (p_idle)
      else $error("read data without read");
   property p_out;
      i_rd && !in_win |=> o_rdata == '0;
   endproperty
   a_out: assert property (p_out)
      else $error("read outside window not zero");
   property p_core_rd;
      i_rd && i_addr == A_ND |=> o_rdata == DATA_W'($past(cnt_d));
   endproperty
   a_core_rd: assert property (p_core_rd)
      else $error("count read not forwarded");
   property p_core_wr;
      i_wr && !i_unit_disable && i_addr == A_NC
      |=> o_core_wr == 6'h04 && o_core_wdata == $past(wlo);
   endproperty
   a_core_wr: assert property (p_core_wr)
      else $error("count write not forwarded");
   property p_no_wr;
      !i_wr || i_unit_disable |=> o_core_wr == 6'h00;
   endproperty
   a_no_wr: assert property (p_no_wr)
      else $error("core write while blocked");
   property p_dis_ctl;
      i_wr && i_unit_disable && i_addr == A_CB |=> $stable(ctl_b);
   endproperty
   a_dis_ctl: assert property (p_dis_ctl)
      else $error("control written while disabled");
   property p_ctl_e;
      i_wr && i_addr == A_CE |=> ctl_e == $past(wlo);
   endproperty
   a_ctl_e: assert property (p_ctl_e)
      else $error("timer five control not written");
   property p_irq;
      1'b1 |=> o_irq == $past(i_irq_event);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt lines not one cycle behind");
   property p_wrap;
      i_tmr_f_wrap ##1 !i_tmr_f_wrap |=> $fell(o_timer_six_wrap_pulse);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("wrap pulse shape wrong");
endmodule

bind tmu_glue tmu_glue_sva #(.DATA_W(DATA_W), .REVISION(REVISION), .UNIT_TYPE(UNIT_TYPE)) u_sva (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_unit_disable(i_unit_disable), .i_src(i_src),
   .o_routed(o_routed), .o_ctrl(o_ctrl), .i_core_value(i_core_value), .o_core_wr(o_core_wr),
   .o_core_wdata(o_core_wdata), .i_irq_event(i_irq_event), .o_irq(o_irq),
   .i_tmr_f_wrap(i_tmr_f_wrap), .o_timer_six_wrap_pulse(o_timer_six_wrap_pulse));

`default_nettype wire

// file: sim/tmu_core_model.sv
/*
 * Far side model: timer cores holding capture/reload and the five counts.
 * Assumes forwarded writes from the glue; cores stand stopped.
 */
`timescale 1ns/1ns
`default_nettype none

module tmu_core_model
(
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic [5:0]       i_core_wr,
   input  wire logic [15:0]      i_core_wdata,
   output logic      [5:0][15:0] o_core_value
);
   // Stopped cores keep read values predictable; clocked by i_clk itself
   always_ff @(posedge i_clk)
   begin
      for (int k = 0; k < 6; k++)
      begin
         if (!i_rst_n)
            o_core_value[k] <= 16'h0000;
         else if (i_core_wr[k])
            o_core_value[k] <= i_core_wdata;
      end
   end
endmodule

`default_nettype wire

// file: sim/tb_timer_unit_input_select_and_map.sv
/*
 * Self-checking bench of the timer unit glue with the core model.
 * Assumes the package constants and the glue hand-over timing.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_timer_unit_input_select_and_map
   import tmu_pkg::*;
;
   localparam logic [7:0]  UT = 8'hA7;  // Arbitrary value
   localparam logic [31:0] B  = TMU_WIN_BASE;
   logic             i_clk, i_rst_n, i_wr, i_rd, i_unit_disable, i_tmr_f_wrap, wrap;
   logic [31:0]      i_addr, i_wdata, o_rdata, d;
   tmu_src_t         i_src;
   tmu_routed_t      o_routed;
   logic [4:0][15:0] o_ctrl;
   logic [5:0][15:0] i_core_value;
   logic [5:0]       o_core_wr, i_irq_event, o_irq, e;
   logic [15:0]      o_core_wdata, s;
   logic [15:0]      m [13];
   logic [31:0]      bad [5];
   int               num_errors, comparisons, n;

   tmu_glue #(.UNIT_TYPE(UT)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_unit_disable(i_unit_disable), .i_src(i_src), .o_routed(o_routed), .o_ctrl(o_ctrl),
      .i_core_value(i_core_value), .o_core_wr(o_core_wr), .o_core_wdata(o_core_wdata),
      .i_irq_event(i_irq_event), .o_irq(o_irq), .i_tmr_f_wrap(i_tmr_f_wrap),
      .o_timer_six_wrap_pulse(wrap));
   tmu_core_model u_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_core_wr(o_core_wr),
      .i_core_wdata(o_core_wdata), .o_core_value(i_core_value));

   ////////////////////////////////////////////////////////////////////////
   // Checking and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] v);
      @(posedge i_clk);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   // Write then read of one address with no gap between the strobes
   task automatic wr_rd(input logic [31:0] a, input logic [31:0] v, output logic [31:0] r);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 r = o_rdata;
   endtask
   // Register write that also updates the expected image
   task automatic wreg(input int i, input logic [31:0] v);
      wr(B + 32'(i * 4), v);
      if (i != 0 && (!i_unit_disable || i == 1 || i == 5)) m[i] = v[15:0];
   endtask
   task automatic chk_all;
      for (int i = 0; i < 13; i++)
      begin
         rd(B + 32'(i * 4), d);
         chk(d, {16'h0000, m[i]});
         if (i >= 2 && i <= 6) chk({16'h0000, o_ctrl[i-2]}, {16'h0000, m[i]});
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Expected routing; read triggers stay idle while this is used
   function automatic tmu_routed_t route(input tmu_sel_t t, input tmu_src_t x);
      tmu_routed_t r;
      r.b_count = x.b_count[t.tmr_b_count_src_sel];
      r.b_dir   = x.b_dir[t.tmr_b_dir_src_sel];
      r.c_count = x.c_count[t.tmr_c_count_src_sel];
      r.c_dir   = x.c_dir[t.tmr_c_dir_src_sel];
      r.d_count = x.d_count[t.tmr_d_count_src_sel];
      r.d_dir   = x.d_dir[t.tmr_d_dir_src_sel];
      r.e_count = x.e_count[t.tmr_e_count_src_sel];
      r.e_dir   = x.e_dir[t.tmr_e_dir_src_sel];
      r.f_count = x.f_count[t.tmr_f_count_src_sel];
      r.f_dir   = x.f_dir[t.tmr_f_dir_src_sel];
      r.capture_trigger_input = !t.capture_trigger_src_sel[1]
         && x.capture_pin[t.capture_trigger_src_sel[0]];
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   initial
   begin
      repeat (20000) @(posedge i_clk);
      num_errors++;
      $display("unexpected at %0t: run too long", $time);
      results;
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {i_rst_n, i_wr, i_rd, i_unit_disable, i_tmr_f_wrap, i_addr, i_wdata} = '0;
      i_src = '0;
      i_irq_event = '0;
      bad = '{B + 32'h34, B + 32'h6, B + 32'h3FFC, B - 32'h4, B + 32'h4000};
      void'($urandom(10));
      foreach (m[i]) m[i] = 16'h0000;
      m[0] = {UT, 8'h01};
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      chk_all;
      $display("test reset done");
      for (int i = 0; i < 13; i++) wreg(i, $urandom);
      chk_all;
      foreach (bad[k])
      begin
         wr(bad[k], $urandom);
         rd(bad[k], d);
         chk(d, 32'h0000_0000);
      end
      chk_all;
      $display("test map done");
      @(posedge i_clk);
      i_unit_disable <= 1'b1;
      for (int i = 0; i < 13; i++) wreg(i, $urandom);
      chk_all;
      @(posedge i_clk);
      i_unit_disable <= 1'b0;
      $display("test disable done");
      // Pins taken as timer inputs are switched to input by software
      for (int k = 0; k < 40; k++)
      begin
         s = (k == 0) ? 16'h0000 : (k == 1) ? 16'h3FFF : 16'($urandom);
         wr_rd(B + 32'h0000_0004, {16'h0000, s}, d);
         m[1] = s;
         chk(d, {16'h0000, s});
         @(posedge i_clk);
         i_src <= tmu_src_t'($urandom);
         repeat (3) @(posedge i_clk);
         #1 d = 32'(route(tmu_sel_t'(m[1]), i_src));
         chk(32'(o_routed), d);
      end
      $display("test routing done");
      wreg(5, 32'h0000_1000);
      for (int md = 2; md < 4; md++)
      begin
         wreg(1, {md[1:0], 14'h0000});
         for (int i = 8; i < 11; i++)
         begin
            rd(B + 32'(i * 4), d);
            chk(d, {16'h0000, m[i]});
            n = 0;
            repeat (4) @(posedge i_clk) #1 n += o_routed.capture_trigger_input;
            chk(32'(n), 32'(i == 9 || md == 3));
         end
      end
      $display("test capture done");
      for (int k = 0; k < 50; k++)
      begin
         @(posedge i_clk);
         e = 6'($urandom);
         i_irq_event <= e;
         i_tmr_f_wrap <= k[0];
         @(posedge i_clk);
         #1 chk({o_irq, wrap}, {e, k[0]});
      end
      $display("test events done");
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (int i = 1; i < 13; i++) m[i] = 16'h0000;
      chk_all;
      $display("test second reset done");
      results;
   end
endmodule

`default_nettype wire
